// File: aiseq_checker.sv
`timescale 1ns/100ps
module aiseq_checker
  import aiseq_pkg::*;
(
  // Clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RST,
  // Inputs watched
  input wire logic        CE,
  input wire logic        LIST_WR,
  input wire logic        LIST_CLEAR,
  input wire logic [4:0]  LIST_CHAN,
  input wire logic        DIFF_MODE,
  input wire logic        STOP,
  input wire logic        CONV_DONE,
  // Outputs watched
  input wire logic        CONV_START,
  input wire logic        RESULT_VALID,
  input wire logic [4:0]  RESULT_CHAN,
  input wire logic        BUSY,
  input wire logic [10:0] LIST_LEN,
  input wire logic        LIST_FULL,
  input wire logic        CHAN_ERROR
);
  logic take;
  assign take = CE && LIST_WR && !LIST_CLEAR && !LIST_FULL && !BUSY;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence s_idle_soon;
    ##[1:2] !BUSY;
  endsequence
  sequence s_err_set;
    ##1 CHAN_ERROR;
  endsequence
  a_conv_single: assert property (CONV_START |=> !CONV_START)
    else $error("conversion start wider than one cycle");
  a_valid_single: assert property (RESULT_VALID |=> !RESULT_VALID)
    else $error("result strobe wider than one cycle");
  a_conv_busy: assert property (CONV_START |-> BUSY)
    else $error("conversion started while idle");
  a_len_step: assert property (take |=> LIST_LEN == $past(LIST_LEN) + 11'h001)
    else $error("list length did not grow by one");
  a_full_flag: assert property (LIST_FULL == (LIST_LEN == 11'h400))
    else $error("full flag disagrees with length");
  a_diff_error: assert property (take && DIFF_MODE && LIST_CHAN inside {[5'h08:5'h0f]} |-> s_err_set)
    else $error("bad differential channel not flagged");
  a_clear_error: assert property (LIST_CLEAR && !BUSY |=> !CHAN_ERROR)
    else $error("channel error survived clear");
  a_stop_idle: assert property (STOP |-> s_idle_soon)
    else $error("stop did not return to idle");
  a_result_cause: assert property (RESULT_VALID && RESULT_CHAN != DIG_CHAN |-> $past(CONV_DONE, 2))
    else $error("analog result without conversion");
endmodule // aiseq_checker
bind aiseq_top aiseq_checker u_aiseq_checker (.*);

// File: aiseq_conv_model.sv
`timescale 1ns/100ps
module aiseq_conv_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Converter side
  input  wire logic        start,
  input  wire logic [3:0]  chan,
  input  wire logic [3:0]  lat,
  output logic             done,
  output logic [15:0]      data
);
  logic [3:0] cnt_reg;
  logic [3:0] ch_reg;
  // Stale data is inverted so a late read cannot match
  assign data = done ? {12'h5a0, ch_reg} : ~{12'h5a0, ch_reg};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 4'h0;
      ch_reg  <= 4'h0;
      done    <= 1'b0;
    end else begin
      done <= (cnt_reg == 4'h1) && !start;
      if (start) begin
        cnt_reg <= lat;
        ch_reg  <= chan;
      end else if (cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end
endmodule // aiseq_conv_model

// File: aiseq_edge_sync.sv
`timescale 1ns/100ps
module aiseq_edge_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // Pin and its falling edge
  input  wire logic pin,
  output logic      fall
);
  logic s1_reg, s2_reg, s3_reg;
  logic s1_next, s2_next, s3_next;

  always_comb begin
    s1_next = pin;
    s2_next = s1_reg;
    s3_next = s2_reg;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
    end else if (ce) begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
    end
  end

  assign fall = s3_reg & ~s2_reg;
endmodule // aiseq_edge_sync

// File: aiseq_list_mem.sv
`timescale 1ns/100ps
module aiseq_list_mem #(
  parameter int DEPTH = aiseq_pkg::LIST_DEPTH,
  parameter int AW    = aiseq_pkg::LIST_AW,
  parameter int DW    = aiseq_pkg::CHAN_W + 1
) (
  // Clock
  input  wire logic          clk,
  input  wire logic          ce,
  // Write side
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  // Read side
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem [DEPTH];

  // No reset so the array maps to block memory
  always_ff @(posedge clk) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end
endmodule // aiseq_list_mem

// File: aiseq_pkg.sv
package aiseq_pkg;
  localparam int LIST_DEPTH      = 1024;
  localparam int LIST_AW         = 10;
  localparam int PASS_W          = 8;
  localparam int CHAN_W          = 5;
  localparam int RESULT_W        = 16;
  localparam logic [4:0] DIG_CHAN      = 5'h10;
  localparam logic [4:0] SE_MAX_CHAN   = 5'h0f;
  localparam logic [4:0] DIFF_MAX_CHAN = 5'h07;
  localparam logic [LIST_AW-1:0] PTR_RESET = 10'h000;
  localparam logic [PASS_W-1:0]  PASS_RESET = 8'h00;
  localparam real CLK_MHZ         = 10.0;
  localparam real DIG_MAX_MSPS    = 3.0;
  localparam int  DIG_MIN_CYCLES  = (CLK_MHZ / DIG_MAX_MSPS) < 1.0 ? 1 :
                                    int'($floor(CLK_MHZ / DIG_MAX_MSPS));

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_WAIT  = 4'b0010,
    ST_CONV  = 4'b0100,
    ST_STORE = 4'b1000
  } seq_state_type;
endpackage

// File: aiseq_top.sv
`timescale 1ns/100ps
module aiseq_top
  import aiseq_pkg::*;
#(
  parameter int RES_BITS = 16
) (
  // Clock and reset
  input  wire logic                          CLK_SYS,
  input  wire logic                          RST,
  input  wire logic                          CE,
  // List loading
  input  wire logic                          LIST_CLEAR,
  input  wire logic                          LIST_WR,
  input  wire logic [aiseq_pkg::CHAN_W-1:0]  LIST_CHAN,
  input  wire logic                          LIST_INHIBIT,
  // Control
  input  wire logic                          DIFF_MODE,
  input  wire logic                          TRIG_MODE,
  input  wire logic [aiseq_pkg::PASS_W-1:0]  PASS_COUNT,
  input  wire logic                          START,
  input  wire logic                          STOP,
  input  wire logic                          TRIGGER_N,
  input  wire logic                          PACER_N,
  input  wire logic                          BUF_FULL,
  // Converter
  output logic                               CONV_START,
  output logic [3:0]                         MUX_CHAN,
  input  wire logic                          CONV_DONE,
  input  wire logic [RES_BITS-1:0]           CONV_DATA,
  // Digital lines
  input  wire logic [7:0]                    PORT_A,
  input  wire logic [7:0]                    PORT_B,
  // Results
  output logic                               RESULT_VALID,
  output logic [aiseq_pkg::RESULT_W-1:0]     RESULT_DATA,
  output logic [aiseq_pkg::CHAN_W-1:0]       RESULT_CHAN,
  // Status
  output logic                               BUSY,
  output logic [aiseq_pkg::LIST_AW:0]        LIST_LEN,
  output logic                               LIST_FULL,
  output logic                               CHAN_ERROR
);
  import aiseq_pkg::*;

  function automatic logic chan_ok(input logic [CHAN_W-1:0] c,
                                   input logic diff);
    if (c == DIG_CHAN) begin
      chan_ok = 1'b1;
    end else if (diff) begin
      chan_ok = (c <= DIFF_MAX_CHAN);
    end else begin
      chan_ok = (c <= SE_MAX_CHAN);
    end
  endfunction

  // Input pins: pacer edge and trigger edge, synchronised
  logic pace_fall, trig_fall;
  logic [7:0] pa_s1_reg, pa_s2_reg, pb_s1_reg, pb_s2_reg;

  aiseq_edge_sync u_pace (
    .clk (CLK_SYS),
    .rst (RST),
    .ce  (CE),
    .pin (PACER_N),
    .fall(pace_fall)
  );

  aiseq_edge_sync u_trig (
    .clk (CLK_SYS),
    .rst (RST),
    .ce  (CE),
    .pin (TRIGGER_N),
    .fall(trig_fall)
  );

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pa_s1_reg <= 8'h00;
      pa_s2_reg <= 8'h00;
      pb_s1_reg <= 8'h00;
      pb_s2_reg <= 8'h00;
    end else if (CE) begin
      pa_s1_reg <= PORT_A;
      pa_s2_reg <= pa_s1_reg;
      pb_s1_reg <= PORT_B;
      pb_s2_reg <= pb_s1_reg;
    end
  end

  // List storage
  logic [LIST_AW:0]   len_reg, len_next;
  logic [LIST_AW-1:0] ptr_reg, ptr_next;
  logic [CHAN_W:0]    entry;
  logic               err_reg, err_next;
  logic               list_we;

  assign list_we = LIST_WR && !len_reg[LIST_AW] && !BUSY;

  aiseq_list_mem #(
    .DEPTH(LIST_DEPTH),
    .AW   (LIST_AW),
    .DW   (CHAN_W + 1)
  ) u_list (
    .clk    (CLK_SYS),
    .ce     (CE),
    .wr_en  (list_we),
    .wr_addr(len_reg[LIST_AW-1:0]),
    .wr_data({LIST_INHIBIT, LIST_CHAN}),
    .rd_addr(ptr_reg),
    .rd_data(entry)
  );

  // Sequencer
  seq_state_type      state_reg, state_next;
  logic [PASS_W-1:0]  pass_reg, pass_next;
  logic               armed_reg, armed_next;
  logic               inh_reg, inh_next;
  logic [CHAN_W-1:0]  chan_reg, chan_next;
  logic               rv_reg, rv_next;
  logic [RESULT_W-1:0] rd_reg, rd_next;
  logic [CHAN_W-1:0]  rc_reg, rc_next;
  logic               cs_reg, cs_next;
  logic               last_entry, last_pass;

  assign last_entry = ({1'b0, ptr_reg} == len_reg - 11'h001);
  assign last_pass  = (pass_reg == PASS_COUNT);

  always_comb begin
    state_next = state_reg;
    ptr_next   = ptr_reg;
    pass_next  = pass_reg;
    armed_next = armed_reg;
    inh_next   = inh_reg;
    chan_next  = chan_reg;
    len_next   = len_reg;
    err_next   = err_reg;
    rv_next    = 1'b0;
    rd_next    = rd_reg;
    rc_next    = rc_reg;
    cs_next    = 1'b0;
    if (LIST_CLEAR && state_reg == ST_IDLE) begin
      len_next = '0;
      err_next = 1'b0;
    end else if (list_we) begin
      len_next = len_reg + 11'h001;
      if (!chan_ok(LIST_CHAN, DIFF_MODE)) begin
        err_next = 1'b1;
      end
    end
    unique case (state_reg)
      ST_IDLE: begin
        if (START && len_reg != '0) begin
          ptr_next   = PTR_RESET;
          pass_next  = PASS_RESET;
          armed_next = !TRIG_MODE;
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (TRIG_MODE && !armed_reg && trig_fall) begin
          armed_next = 1'b1;
        end
        if (STOP || BUF_FULL) begin
          state_next = ST_IDLE;
        end else if (armed_reg && pace_fall) begin
          // Same pacing for analog and digital entries
          chan_next  = entry[CHAN_W-1:0];
          inh_next   = entry[CHAN_W];
          state_next = (entry[CHAN_W-1:0] == DIG_CHAN) ? ST_STORE
                                                       : ST_CONV;
          cs_next    = (entry[CHAN_W-1:0] != DIG_CHAN);
          if (entry[CHAN_W-1:0] == DIG_CHAN) begin
            // Digital word needs no converter: one cycle keeps 3 MS/s
            rd_next = {pb_s2_reg, pa_s2_reg};
          end
        end
      end
      ST_CONV: begin
        if (STOP) begin
          state_next = ST_IDLE;
        end else if (CONV_DONE) begin
          rd_next    = RESULT_W'(CONV_DATA);
          state_next = ST_STORE;
        end
      end
      ST_STORE: begin
        rv_next = !inh_reg;
        rc_next = chan_reg;
        state_next = ST_WAIT;
        if (last_entry) begin
          ptr_next = PTR_RESET;
          if (TRIG_MODE) begin
            if (last_pass) begin
              pass_next  = PASS_RESET;
              armed_next = 1'b0;
            end else begin
              pass_next = pass_reg + 8'h01;
            end
          end
        end else begin
          ptr_next = ptr_reg + 10'h001;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_reg <= ST_IDLE;
      ptr_reg   <= PTR_RESET;
      pass_reg  <= PASS_RESET;
      armed_reg <= 1'b0;
      inh_reg   <= 1'b0;
      chan_reg  <= '0;
      len_reg   <= '0;
      err_reg   <= 1'b0;
      rv_reg    <= 1'b0;
      rd_reg    <= '0;
      rc_reg    <= '0;
      cs_reg    <= 1'b0;
    end else if (CE) begin
      state_reg <= state_next;
      ptr_reg   <= ptr_next;
      pass_reg  <= pass_next;
      armed_reg <= armed_next;
      inh_reg   <= inh_next;
      chan_reg  <= chan_next;
      len_reg   <= len_next;
      err_reg   <= err_next;
      rv_reg    <= rv_next;
      rd_reg    <= rd_next;
      rc_reg    <= rc_next;
      cs_reg    <= cs_next;
    end
  end

  assign CONV_START   = cs_reg;
  assign MUX_CHAN     = chan_reg[3:0];
  assign RESULT_VALID = rv_reg;
  assign RESULT_DATA  = rd_reg;
  assign RESULT_CHAN  = rc_reg;
  assign BUSY         = (state_reg != ST_IDLE);
  assign LIST_LEN     = len_reg;
  assign LIST_FULL    = len_reg[LIST_AW];
  assign CHAN_ERROR   = err_reg;
endmodule // aiseq_top

// File: tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import aiseq_pkg::*;
  logic CLK_SYS = 1'b0, RST = 1'b1, CE = 1'b1, BUF_FULL = 1'b0;
  logic LIST_CLEAR = 1'b0, LIST_WR = 1'b0, LIST_INHIBIT = 1'b0;
  logic DIFF_MODE = 1'b0, TRIG_MODE = 1'b0, START = 1'b0, STOP = 1'b0;
  logic TRIGGER_N = 1'b1, PACER_N = 1'b1;
  logic [4:0] LIST_CHAN = 5'h00;
  logic [7:0] PASS_COUNT = 8'h00, PORT_A = 8'h3c, PORT_B = 8'hc3;
  logic [3:0] lat = 4'h1;
  logic CONV_DONE, CONV_START, RESULT_VALID, BUSY, LIST_FULL, CHAN_ERROR;
  logic [15:0] CONV_DATA, RESULT_DATA;
  logic [3:0] MUX_CHAN;
  logic [4:0] RESULT_CHAN;
  logic [10:0] LIST_LEN;
  int bad_count = 0;
  int checks_done = 0;
  always #50 CLK_SYS = ~CLK_SYS;
  aiseq_top u_aiseq_top (.*);
  aiseq_conv_model u_aiseq_conv_model (.clk(CLK_SYS), .rst(RST),
    .start(CONV_START), .chan(MUX_CHAN), .lat(lat), .done(CONV_DONE),
    .data(CONV_DATA));
  task chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value at %0t: %h expected %h", $time, s, e);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge CLK_SYS);
    s = 1'b1;
    @(negedge CLK_SYS);
    s = 1'b0;
  endtask
  task wr(input logic [4:0] c, input logic inh);
    @(negedge CLK_SYS);
    LIST_CHAN = c;
    LIST_INHIBIT = inh;
    LIST_WR = 1'b1;
    @(negedge CLK_SYS);
    LIST_WR = 1'b0;
  endtask
  // One pacer edge, then count and judge the results it yields
  task step(input logic [15:0] d, input logic [4:0] c, input logic k);
    int n;
    n = 0;
    @(negedge CLK_SYS);
    PACER_N = 1'b0;
    repeat (20) begin
      @(negedge CLK_SYS);
      PACER_N = 1'b1;
      if (RESULT_VALID === 1'b1) begin
        n++;
        chk(RESULT_DATA, d);
        chk(16'(RESULT_CHAN), 16'(c));
      end
    end
    chk(16'(n), 16'(k));
  endtask
  task t_diff;
    DIFF_MODE = 1'b1;
    pulse(LIST_CLEAR);
    wr(5'h07, 1'b0);
    chk(16'(CHAN_ERROR), 16'h0000);
    wr(5'h08, 1'b0);
    chk(16'(CHAN_ERROR), 16'h0001);
    pulse(LIST_CLEAR);
    chk(16'(CHAN_ERROR), 16'h0000);
    DIFF_MODE = 1'b0;
    $display("t_diff done");
  endtask
  task t_cont;
    pulse(LIST_CLEAR);
    wr(5'h03, 1'b0);
    wr(DIG_CHAN, 1'b0);
    wr(5'h03, 1'b1);
    wr(5'h0f, 1'b0);
    chk(16'(LIST_LEN), 16'h0004);
    pulse(START);
    step(16'h5a03, 5'h03, 1'b1);
    step(16'hc33c, DIG_CHAN, 1'b1);
    step(16'h5a03, 5'h03, 1'b0);
    step(16'h5a0f, 5'h0f, 1'b1);
    step(16'h5a03, 5'h03, 1'b1);
    pulse(STOP);
    @(negedge CLK_SYS);
    chk(16'(BUSY), 16'h0000);
    $display("t_cont done");
  endtask
  // Slow converter; 256 passes of a lone digital entry
  task t_trig;
    lat = 4'h6;
    TRIG_MODE = 1'b1;
    PASS_COUNT = 8'hff;
    pulse(LIST_CLEAR);
    wr(DIG_CHAN, 1'b0);
    pulse(START);
    step(16'hc33c, DIG_CHAN, 1'b0);
    pulse(TRIGGER_N);
    TRIGGER_N = 1'b0;
    repeat (3) @(negedge CLK_SYS);
    TRIGGER_N = 1'b1;
    repeat (256) step(16'hc33c, DIG_CHAN, 1'b1);
    step(16'hc33c, DIG_CHAN, 1'b0);
    chk(16'(BUSY), 16'h0001);
    pulse(STOP);
    TRIG_MODE = 1'b0;
    $display("t_trig done");
  endtask
  // Pacer every third cycle on a lone digital entry, then a full buffer
  task t_fast;
    int n;
    n = 0;
    pulse(LIST_CLEAR);
    wr(DIG_CHAN, 1'b0);
    pulse(START);
    for (int i = 0; i < 32; i++) begin
      @(negedge CLK_SYS);
      PACER_N = !(i < 24 && i % 3 == 0);
      if (RESULT_VALID === 1'b1) begin
        n++;
      end
    end
    chk(16'(n), 16'h0008);
    pulse(STOP);
    pulse(START);
    BUF_FULL = 1'b1;
    @(negedge CLK_SYS);
    chk(16'(BUSY), 16'h0000);
    BUF_FULL = 1'b0;
    $display("t_fast done");
  endtask
  task t_full;
    pulse(LIST_CLEAR);
    repeat (1024) wr(5'h01, 1'b0);
    chk(16'(LIST_FULL), 16'h0001);
    wr(5'h02, 1'b0);
    chk(16'(LIST_LEN), 16'h0400);
    $display("t_full done");
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge CLK_SYS);
    RST = 1'b0;
    t_diff;
    t_cont;
    t_trig;
    t_fast;
    t_full;
    end_sim;
  end
  // About 8,000 cycles expected; cut off at 20,000
  initial begin
    #2000000;
    bad_count++;
    end_sim;
  end
endmodule // tb_top
